// *** common/csf_params.svh ***
// constants of the cpu status flag register
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CSF_ADDR_FLAGS 4'h0
`define CSF_ADDR_NEST 4'h1
`define CSF_ADDR_INT_STATUS 4'h2
`define CSF_ADDR_INT_ENABLE 4'h3
`define CSF_ADDR_INT_CLEAR 4'h4

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define CSF_BIT_ACC_A_OVF 15
`define CSF_BIT_ACC_B_OVF 14
`define CSF_BIT_ACC_A_SAT 13
`define CSF_BIT_ACC_B_SAT 12
`define CSF_BIT_ANY_OVF 11
`define CSF_BIT_ANY_SAT 10
`define CSF_BIT_LOOP 9
`define CSF_BIT_HALF_CARRY 8
`define CSF_BIT_PRIO_HI 7
`define CSF_BIT_PRIO_LO 5
`define CSF_BIT_LOW_TOP 4
`define CSF_BIT_NEST_DISABLE 15

// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define CSF_FLAGS_RESET 16'h0000
`define CSF_EVT_WIDTH 4
`define CSF_EVT_RESET 4'h0

`endif

// *** common/csf_pkg.sv ***
// types of the cpu status flag register
package csf_pkg;

	typedef enum logic [1:0] {
		CSF_EVT_SAT_A = 2'b00,
		CSF_EVT_SAT_B = 2'b01,
		CSF_EVT_OVF = 2'b10,
		CSF_EVT_LOOP = 2'b11
	} csf_evt_type;

	typedef struct packed {
		logic [3:0] status;
		logic [3:0] enable;
	} csf_irq_state_type;

	typedef struct packed {
		logic acc_a_overflow;
		logic acc_b_overflow;
		logic acc_a_saturated_sticky;
		logic acc_b_saturated_sticky;
		logic loop_active;
		logic half_carry;
		logic [2:0] cpu_priority_level;
		logic [4:0] low_flags;
		logic nesting_disable;
		logic [15:0] read_data;
	} csf_state_type;

endpackage

// *** core/csf_half_carry.sv ***
// half carry detector for byte and word alu operations
`timescale 1ns/100ps
`include "csf_params.svh"

module csf_half_carry
	import csf_pkg::*;
(
	// operands
	input wire logic [15:0] opnd_a,
	input wire logic [15:0] opnd_b,
	input wire logic subtract,
	input wire logic byte_op,
	// result
	output logic half_carry
);
	logic [4:0] sum4;
	logic [8:0] sum8;

	// carry (or no-borrow) out of bit 3 or bit 7
	always_comb begin
		sum4 = {1'b0, opnd_a[3:0]} + {1'b0, (subtract ? ~opnd_b[3:0] : opnd_b[3:0])}
			+ {4'h0, subtract};
		sum8 = {1'b0, opnd_a[7:0]} + {1'b0, (subtract ? ~opnd_b[7:0] : opnd_b[7:0])}
			+ {8'h00, subtract};
		half_carry = byte_op ? sum4[4] : sum8[8];
	end
endmodule // csf_half_carry

// *** core/csf_irq.sv ***
// sticky event status, enable and clear for the interrupt output
`timescale 1ns/100ps
`include "csf_params.svh"

module csf_irq
	import csf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// events and software access
	input wire logic [3:0] events,
	input wire logic enable_write,
	input wire logic clear_write,
	input wire logic [3:0] write_data,
	// state
	output logic [3:0] status,
	output logic [3:0] enable,
	output logic irq
);
	csf_irq_state_type state;
	csf_irq_state_type next_state;

	always_comb begin
		next_state = state;
		if (enable_write) begin
			next_state.enable = write_data;
		end
		// set wins over clear
		for (int i = 0; i < `CSF_EVT_WIDTH; i++) begin
			if (events[i]) begin
				next_state.status[i] = 1'b1;
			end else if (clear_write && write_data[i]) begin
				next_state.status[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '{status: `CSF_EVT_RESET, enable: `CSF_EVT_RESET};
		end else begin
			state <= next_state;
		end
	end

	assign status = state.status;
	assign enable = state.enable;
	assign irq = |(state.status & state.enable);

	a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
		(|(events & state.enable)) && !enable_write |=> irq)
		else $error("enabled event did not raise irq");
	a_event_sticks: assert property (@(posedge clk) disable iff (!reset_n)
		events[0] |=> status[0])
		else $error("event did not set status");
endmodule // csf_irq

// *** core/csf_status_flags.sv ***
// cpu status flag register with alu and accumulator updates
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
`include "csf_params.svh"

module csf_status_flags
	import csf_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WRITE,
	input wire logic REG_READ,
	output logic [15:0] REG_RDATA,
	// accumulator condition updates
	input wire logic ACC_UPDATE,
	input wire logic ACC_A_OVERFLOW_IN,
	input wire logic ACC_B_OVERFLOW_IN,
	input wire logic ACC_A_SATURATE,
	input wire logic ACC_B_SATURATE,
	// loop control
	input wire logic LOOP_START,
	input wire logic LOOP_END,
	// alu operation
	input wire logic ALU_UPDATE,
	input wire logic [15:0] ALU_OPND_A,
	input wire logic [15:0] ALU_OPND_B,
	input wire logic ALU_SUBTRACT,
	input wire logic ALU_BYTE_OP,
	input wire logic [4:0] ALU_LOW_FLAGS,
	// priority level from the interrupt controller
	input wire logic PRIORITY_UPDATE,
	input wire logic [2:0] PRIORITY_IN,
	// status
	output logic [15:0] CPU_STATUS_FLAGS,
	output logic IRQ
);
	csf_state_type state;
	csf_state_type next_state;
	logic hc_result;
	logic [3:0] irq_status;
	logic [3:0] irq_enable;
	logic [3:0] events;
	logic any_acc_overflow;
	logic any_acc_saturated;
	logic [15:0] flags;
	logic flags_write;
	logic nest_write;
	logic enable_write;
	logic clear_write;

	// ----------------------------------------
	// half carry and event status
	// ----------------------------------------
	csf_half_carry csf_half_carry_i (
		.opnd_a(ALU_OPND_A),
		.opnd_b(ALU_OPND_B),
		.subtract(ALU_SUBTRACT),
		.byte_op(ALU_BYTE_OP),
		.half_carry(hc_result)
	);

	assign events[CSF_EVT_SAT_A] = ACC_UPDATE && ACC_A_SATURATE;
	assign events[CSF_EVT_SAT_B] = ACC_UPDATE && ACC_B_SATURATE;
	assign events[CSF_EVT_OVF] = ACC_UPDATE && (ACC_A_OVERFLOW_IN || ACC_B_OVERFLOW_IN);
	assign events[CSF_EVT_LOOP] = LOOP_END && state.loop_active;

	assign flags_write = REG_WRITE && (REG_ADDR == `CSF_ADDR_FLAGS);
	assign nest_write = REG_WRITE && (REG_ADDR == `CSF_ADDR_NEST);
	assign enable_write = REG_WRITE && (REG_ADDR == `CSF_ADDR_INT_ENABLE);
	assign clear_write = REG_WRITE && (REG_ADDR == `CSF_ADDR_INT_CLEAR);

	csf_irq csf_irq_i (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.events(events),
		.enable_write(enable_write),
		.clear_write(clear_write),
		.write_data(REG_WDATA[3:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(IRQ)
	);

	// ----------------------------------------
	// combined flags and register image
	// ----------------------------------------
	assign any_acc_overflow = state.acc_a_overflow || state.acc_b_overflow;
	assign any_acc_saturated = state.acc_a_saturated_sticky || state.acc_b_saturated_sticky;

	always_comb begin
		flags = `CSF_FLAGS_RESET;
		flags[`CSF_BIT_ACC_A_OVF] = state.acc_a_overflow;
		flags[`CSF_BIT_ACC_B_OVF] = state.acc_b_overflow;
		flags[`CSF_BIT_ACC_A_SAT] = state.acc_a_saturated_sticky;
		flags[`CSF_BIT_ACC_B_SAT] = state.acc_b_saturated_sticky;
		flags[`CSF_BIT_ANY_OVF] = any_acc_overflow;
		flags[`CSF_BIT_ANY_SAT] = any_acc_saturated;
		flags[`CSF_BIT_LOOP] = state.loop_active;
		flags[`CSF_BIT_HALF_CARRY] = state.half_carry;
		flags[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO] = state.cpu_priority_level;
		flags[`CSF_BIT_LOW_TOP:0] = state.low_flags;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		// software write first, hardware updates override it in the same cycle
		if (flags_write) begin
			next_state.acc_a_overflow = REG_WDATA[`CSF_BIT_ACC_A_OVF];
			next_state.acc_b_overflow = REG_WDATA[`CSF_BIT_ACC_B_OVF];
			next_state.acc_a_saturated_sticky = REG_WDATA[`CSF_BIT_ACC_A_SAT];
			next_state.acc_b_saturated_sticky = REG_WDATA[`CSF_BIT_ACC_B_SAT];
			if (!REG_WDATA[`CSF_BIT_ANY_SAT]) begin
				next_state.acc_a_saturated_sticky = 1'b0;
				next_state.acc_b_saturated_sticky = 1'b0;
			end
			next_state.half_carry = REG_WDATA[`CSF_BIT_HALF_CARRY];
			if (!state.nesting_disable) begin
				next_state.cpu_priority_level =
					REG_WDATA[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO];
			end
			// bit 4 is read only
			next_state.low_flags = {state.low_flags[4], REG_WDATA[3:0]};
		end
		if (nest_write) begin
			next_state.nesting_disable = REG_WDATA[`CSF_BIT_NEST_DISABLE];
		end
		if (ACC_UPDATE) begin
			next_state.acc_a_overflow = ACC_A_OVERFLOW_IN;
			next_state.acc_b_overflow = ACC_B_OVERFLOW_IN;
			if (ACC_A_SATURATE) begin
				next_state.acc_a_saturated_sticky = 1'b1;
			end
			if (ACC_B_SATURATE) begin
				next_state.acc_b_saturated_sticky = 1'b1;
			end
		end
		if (LOOP_START) begin
			next_state.loop_active = 1'b1;
		end else if (LOOP_END) begin
			next_state.loop_active = 1'b0;
		end
		if (ALU_UPDATE) begin
			next_state.half_carry = hc_result;
			next_state.low_flags = {state.low_flags[4], ALU_LOW_FLAGS[3:0]};
		end
		if (PRIORITY_UPDATE) begin
			next_state.cpu_priority_level = PRIORITY_IN;
		end
		// read data registered for the cycle after the strobe
		unique case (REG_ADDR)
			`CSF_ADDR_FLAGS: next_state.read_data = flags;
			`CSF_ADDR_NEST: next_state.read_data = {state.nesting_disable, 15'h0000};
			`CSF_ADDR_INT_STATUS: next_state.read_data = {12'h000, irq_status};
			`CSF_ADDR_INT_ENABLE: next_state.read_data = {12'h000, irq_enable};
			default: next_state.read_data = 16'h0000;
		endcase
		if (!REG_READ) begin
			next_state.read_data = 16'h0000;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign REG_RDATA = state.read_data;
	assign CPU_STATUS_FLAGS = flags;

	// ----------------------------------------
	// assertion sequences
	// ----------------------------------------
	sequence s_sat_a;
		ACC_UPDATE && ACC_A_SATURATE;
	endsequence

	sequence s_sat_b;
		ACC_UPDATE && ACC_B_SATURATE;
	endsequence

	sequence s_no_sat_clear;
		!(flags_write && (!REG_WDATA[`CSF_BIT_ACC_A_SAT] || !REG_WDATA[`CSF_BIT_ANY_SAT]));
	endsequence

	sequence s_no_sat_b_clear;
		!(flags_write && (!REG_WDATA[`CSF_BIT_ACC_B_SAT] || !REG_WDATA[`CSF_BIT_ANY_SAT]));
	endsequence

	sequence s_no_overflow;
		ACC_UPDATE && !ACC_A_OVERFLOW_IN && !ACC_B_OVERFLOW_IN;
	endsequence

	sequence s_byte_carry;
		ALU_UPDATE && ALU_BYTE_OP && !ALU_SUBTRACT
			&& (ALU_OPND_A[3:0] == 4'hf) && (ALU_OPND_B[3:0] == 4'h1);
	endsequence

	sequence s_byte_borrow;
		ALU_UPDATE && ALU_BYTE_OP && ALU_SUBTRACT
			&& (ALU_OPND_A[3:0] == 4'h0) && (ALU_OPND_B[3:0] == 4'h1);
	endsequence

	sequence s_word_carry;
		ALU_UPDATE && !ALU_BYTE_OP && !ALU_SUBTRACT
			&& (ALU_OPND_A[7:0] == 8'hff) && (ALU_OPND_B[7:0] == 8'h01);
	endsequence

	sequence s_word_no_carry;
		ALU_UPDATE && !ALU_BYTE_OP && !ALU_SUBTRACT
			&& (ALU_OPND_A[7:0] == 8'h0f) && (ALU_OPND_B[7:0] == 8'h01);
	endsequence

	sequence s_prio_write;
		flags_write && !state.nesting_disable && !PRIORITY_UPDATE;
	endsequence

	sequence s_loop_end;
		LOOP_END && !LOOP_START;
	endsequence

	// ----------------------------------------
	// saturation flags
	// ----------------------------------------
	a_sat_a_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_sat_a ##1 s_no_sat_clear |=> state.acc_a_saturated_sticky)
		else $error("accumulator a saturation flag not sticky");
	a_sat_a_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		state.acc_a_saturated_sticky && !flags_write |=> state.acc_a_saturated_sticky)
		else $error("accumulator a saturation flag dropped without a write");
	a_sat_b_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_sat_b ##1 s_no_sat_b_clear |=> state.acc_b_saturated_sticky)
		else $error("accumulator b saturation flag not sticky");
	a_sat_b_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		state.acc_b_saturated_sticky && !flags_write |=> state.acc_b_saturated_sticky)
		else $error("accumulator b saturation flag dropped without a write");

	// ----------------------------------------
	// overflow flags
	// ----------------------------------------
	a_ovf_or: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		ACC_UPDATE |=> CPU_STATUS_FLAGS[`CSF_BIT_ANY_OVF]
			== ($past(ACC_A_OVERFLOW_IN) || $past(ACC_B_OVERFLOW_IN)))
		else $error("combined overflow not the or of both");
	a_ovf_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_no_overflow |=> !CPU_STATUS_FLAGS[`CSF_BIT_ANY_OVF])
		else $error("combined overflow set while neither accumulator overflowed");
	a_ovf_b_track: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		ACC_UPDATE |=> CPU_STATUS_FLAGS[`CSF_BIT_ACC_B_OVF] == $past(ACC_B_OVERFLOW_IN))
		else $error("accumulator b overflow flag does not track its input");
	a_ovf_event: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		ACC_UPDATE && (ACC_A_OVERFLOW_IN || ACC_B_OVERFLOW_IN) |=> irq_status[CSF_EVT_OVF])
		else $error("overflow did not set its event status");

	// ----------------------------------------
	// half carry
	// ----------------------------------------
	a_byte_carry: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_byte_carry |=> CPU_STATUS_FLAGS[`CSF_BIT_HALF_CARRY])
		else $error("half carry missing on byte carry");
	a_byte_borrow: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_byte_borrow |=> !CPU_STATUS_FLAGS[`CSF_BIT_HALF_CARRY])
		else $error("half carry set on byte borrow");
	a_word_carry: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_word_carry |=> CPU_STATUS_FLAGS[`CSF_BIT_HALF_CARRY])
		else $error("half carry missing on word carry");
	a_word_no_carry: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_word_no_carry |=> !CPU_STATUS_FLAGS[`CSF_BIT_HALF_CARRY])
		else $error("half carry set without word carry");

	// ----------------------------------------
	// priority level
	// ----------------------------------------
	a_prio_locked: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		state.nesting_disable && !PRIORITY_UPDATE |=> $stable(state.cpu_priority_level))
		else $error("priority level changed while locked");
	a_prio_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_prio_write |=> CPU_STATUS_FLAGS[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO]
			== $past(REG_WDATA[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO]))
		else $error("priority level not loaded while unlocked");
	a_prio_update: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		PRIORITY_UPDATE |=> state.cpu_priority_level == $past(PRIORITY_IN))
		else $error("priority level not loaded from the controller");

	// ----------------------------------------
	// saturation writes
	// ----------------------------------------
	a_sat_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		flags_write && REG_WDATA[`CSF_BIT_ANY_SAT] && !ACC_UPDATE
		|=> state.acc_b_saturated_sticky == $past(REG_WDATA[`CSF_BIT_ACC_B_SAT]))
		else $error("saturation flag not loaded by write");
	a_sat_a_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		flags_write && REG_WDATA[`CSF_BIT_ANY_SAT] && !ACC_UPDATE
		|=> state.acc_a_saturated_sticky == $past(REG_WDATA[`CSF_BIT_ACC_A_SAT]))
		else $error("accumulator a saturation flag not loaded by write");
	a_sat_clear: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		flags_write && !REG_WDATA[`CSF_BIT_ANY_SAT] && !ACC_UPDATE
		|=> !CPU_STATUS_FLAGS[`CSF_BIT_ACC_A_SAT] && !CPU_STATUS_FLAGS[`CSF_BIT_ACC_B_SAT])
		else $error("combined saturation clear failed");

	// ----------------------------------------
	// loop flag
	// ----------------------------------------
	a_loop_flag: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		LOOP_START |=> CPU_STATUS_FLAGS[`CSF_BIT_LOOP])
		else $error("loop flag not set on start");
	a_loop_end: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		s_loop_end |=> !CPU_STATUS_FLAGS[`CSF_BIT_LOOP])
		else $error("loop flag not cleared on end");
	a_loop_event: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		LOOP_END && state.loop_active |=> irq_status[CSF_EVT_LOOP])
		else $error("loop end did not set its event status");

	// ----------------------------------------
	// read port
	// ----------------------------------------
	a_read_timing: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		REG_READ && (REG_ADDR == `CSF_ADDR_FLAGS) && !flags_write |=> REG_RDATA == $past(flags))
		else $error("read data not the flags of the strobe cycle");
	a_read_idle: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		!REG_READ |=> REG_RDATA == 16'h0000)
		else $error("read data not zero outside a read");
	a_read_unmapped: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		REG_READ && (REG_ADDR > `CSF_ADDR_INT_ENABLE) |=> REG_RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_read_nest: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		REG_READ && (REG_ADDR == `CSF_ADDR_NEST)
		|=> REG_RDATA[`CSF_BIT_NEST_DISABLE] == $past(state.nesting_disable))
		else $error("nesting control read wrong");
endmodule // csf_status_flags

// *** sim/csf_status_flags_bench.sv ***
// self-checking bench of the cpu status flag register
`timescale 1ns/100ps
`include "csf_params.svh"

module csf_status_flags_bench
	import csf_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic acc_upd = 1'b0;
	logic [3:0] acc = 4'h0;
	logic ls = 1'b0;
	logic le = 1'b0;
	logic alu_upd = 1'b0;
	logic [15:0] opa = 16'h0000;
	logic [15:0] opb = 16'h0000;
	logic sub = 1'b0;
	logic bop = 1'b0;
	logic pr_upd = 1'b0;
	logic [2:0] pr = 3'h0;
	logic [15:0] flags;
	logic irq;
	int error_cnt = 0;
	int num_checks = 0;

	csf_status_flags csf_status_flags_i (.CLK_SYS(clk), .RESET_N(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WRITE(wr), .REG_READ(rd), .REG_RDATA(rdata),
		.ACC_UPDATE(acc_upd), .ACC_A_OVERFLOW_IN(acc[0]), .ACC_B_OVERFLOW_IN(acc[1]),
		.ACC_A_SATURATE(acc[2]), .ACC_B_SATURATE(acc[3]), .LOOP_START(ls), .LOOP_END(le),
		.ALU_UPDATE(alu_upd), .ALU_OPND_A(opa), .ALU_OPND_B(opb), .ALU_SUBTRACT(sub),
		.ALU_BYTE_OP(bop), .ALU_LOW_FLAGS(5'h0a), .PRIORITY_UPDATE(pr_upd),
		.PRIORITY_IN(pr), .CPU_STATUS_FLAGS(flags), .IRQ(irq));

	always #50 clk = ~clk;

	// ----------------------------------------
	// bus and stimulus helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask

	task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask

	task automatic accp(input logic [3:0] v);
		@(posedge clk);
		acc_upd <= 1'b1;
		acc <= v;
		@(posedge clk);
		acc_upd <= 1'b0;
		@(negedge clk);
	endtask

	task automatic alu(input logic [15:0] a, input logic [15:0] b, input logic s,
		input logic by, input logic e);
		@(posedge clk);
		alu_upd <= 1'b1;
		opa <= a;
		opb <= b;
		sub <= s;
		bop <= by;
		@(posedge clk);
		alu_upd <= 1'b0;
		@(negedge clk);
		chk({15'h0000, flags[`CSF_BIT_HALF_CARRY]}, {15'h0000, e});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_overflow();
		for (int i = 0; i < 4; i++) begin
			accp(i[3:0]);
			chk(flags & 16'hc800, {i[0], i[1], 2'b00, |i[1:0], 11'h000});
		end
		$display("test overflow done");
	endtask

	task automatic t_sticky();
		accp(4'h4);
		accp(4'h0);
		chk(flags & 16'h3400, 16'h2400);
		accp(4'h8);
		accp(4'h0);
		chk(flags & 16'h3400, 16'h3400);
		wreg(`CSF_ADDR_FLAGS, 16'h0000);
		chk(flags & 16'h3400, 16'h0000);
		wreg(`CSF_ADDR_FLAGS, 16'h3400);
		chk(flags & 16'h3400, 16'h3400);
		wreg(`CSF_ADDR_FLAGS, 16'h2400);
		rreg(`CSF_ADDR_FLAGS, 16'h2400);
		$display("test sticky done");
	endtask

	task automatic t_half_carry();
		alu(16'h000f, 16'h0001, 1'b0, 1'b1, 1'b1);
		alu(16'h00f0, 16'h0010, 1'b0, 1'b1, 1'b0);
		alu(16'h00ff, 16'h0001, 1'b0, 1'b0, 1'b1);
		alu(16'h000f, 16'h0001, 1'b0, 1'b0, 1'b0);
		alu(16'h0010, 16'h0001, 1'b1, 1'b1, 1'b0);
		alu(16'h0011, 16'h0001, 1'b1, 1'b1, 1'b1);
		chk(flags & 16'h001f, 16'h000a);
		$display("test half carry done");
	endtask

	task automatic t_priority();
		wreg(`CSF_ADDR_FLAGS, 16'h00b0);
		rreg(`CSF_ADDR_FLAGS, 16'h00a0);
		wreg(`CSF_ADDR_NEST, 16'h8000);
		rreg(`CSF_ADDR_NEST, 16'h8000);
		wreg(`CSF_ADDR_FLAGS, 16'h0040);
		chk({13'h0000, flags[7:5]}, 16'h0005);
		@(posedge clk);
		pr_upd <= 1'b1;
		pr <= 3'h3;
		@(posedge clk);
		pr_upd <= 1'b0;
		@(negedge clk);
		chk({13'h0000, flags[7:5]}, 16'h0003);
		wreg(`CSF_ADDR_NEST, 16'h0000);
		wreg(`CSF_ADDR_FLAGS, 16'h0040);
		chk({13'h0000, flags[7:5]}, 16'h0002);
		$display("test priority done");
	endtask

	task automatic t_irq_loop();
		wreg(`CSF_ADDR_INT_CLEAR, 16'h000f);
		wreg(`CSF_ADDR_INT_ENABLE, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		accp(4'h4);
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0001);
		rreg(`CSF_ADDR_INT_STATUS, 16'h0001);
		wreg(`CSF_ADDR_INT_ENABLE, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		wreg(`CSF_ADDR_INT_ENABLE, 16'h0001);
		wreg(`CSF_ADDR_INT_CLEAR, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		rreg(`CSF_ADDR_INT_ENABLE, 16'h0001);
		@(posedge clk);
		acc_upd <= 1'b1;
		acc <= 4'h4;
		wr <= 1'b1;
		addr <= `CSF_ADDR_INT_CLEAR;
		wdata <= 16'h0001;
		@(posedge clk);
		acc_upd <= 1'b0;
		wr <= 1'b0;
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0001);
		wreg(`CSF_ADDR_INT_CLEAR, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		rreg(4'hf, 16'h0000);
		@(posedge clk);
		ls <= 1'b1;
		@(posedge clk);
		ls <= 1'b0;
		@(negedge clk);
		chk(flags & 16'h0200, 16'h0200);
		@(posedge clk);
		le <= 1'b1;
		@(posedge clk);
		le <= 1'b0;
		@(negedge clk);
		chk(flags & 16'h0200, 16'h0000);
		rreg(`CSF_ADDR_INT_STATUS, 16'h0008);
		$display("test irq and loop done");
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#(3000 * 100);
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(flags, `CSF_FLAGS_RESET);
		rreg(`CSF_ADDR_FLAGS, `CSF_FLAGS_RESET);
		t_overflow();
		t_sticky();
		t_half_carry();
		t_priority();
		t_irq_loop();
		finish_test();
	end
endmodule // csf_status_flags_bench
